// ### shared/cpf_pkg.sv
// Purpose: constants and types for the codec port frame configuration block
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word per register
// Notes:   serial samples are 16 bits carried in time slot 0 of each frame
package cpf_pkg;
   // -------------------------------------------------------------------------
   // register map (byte addresses)
   // -------------------------------------------------------------------------
   localparam logic [3:0] CPF_ADDR_CFG    = 4'h0;  // framing and byte order bits
   localparam logic [3:0] CPF_ADDR_SLOT0  = 4'h4;  // serial clocks in time slot 0
   localparam logic [3:0] CPF_ADDR_FRAME  = 4'h8;  // serial clocks per frame
   localparam logic [3:0] CPF_ADDR_STATUS = 4'hC;  // read-only block state

   // -------------------------------------------------------------------------
   // field positions and reset values
   // -------------------------------------------------------------------------
   localparam int         CPF_CFG_W       = 6;     // width of config register
   localparam logic [7:0] CPF_CFG_RST     = 8'h30; // edge and level bits set
   localparam logic [7:0] CPF_SLOT0_RST   = 8'h10; // slot 0 of 16 clocks
   localparam logic [7:0] CPF_FRAME_RST   = 8'h20; // frame of 32 clocks
   localparam int         CPF_ST_FRM_LSB  = 8;     // frame counter position
   localparam int         CPF_ST_SYNC     = 0;     // generated sync level
   localparam int         CPF_ST_TXFULL   = 1;     // transmit holding word full
   localparam int         CPF_ST_DIR      = 2;     // sync is an input

   // -------------------------------------------------------------------------
   // widths and timing
   // -------------------------------------------------------------------------
   localparam int         CPF_SAMPLE_W    = 16;    // bits per audio sample
   localparam int         CPF_BYTES       = 2;     // bytes per audio sample
   localparam logic [7:0] CPF_SAMPLE_LAST = 8'h0F; // last bit index of a sample
   localparam int         CPF_SYNC_FF     = 3;     // flip-flops per pin input

   // configuration bits in their register order
   typedef struct packed {
      logic edge_sel;     // serial_clock_edge_select
      logic sync_level;   // sync_level_select
      logic sync_len;     // sync_length_select
      logic byte_swap;    // sample_byte_swap
      logic clk_dir;      // serial_clock_direction
      logic sync_dir;     // sync_direction
   } cpf_cfg_s;
endpackage

// ### rtl/cpf_swap.sv
// Purpose: reverse or keep the byte order of one audio sample
// Assumes: sample width is a whole number of bytes
// Notes:   purely combinational, one instance per transfer direction
`timescale 1ns/1ps
module cpf_swap
   import cpf_pkg::*;
#(
   parameter int BYTES = CPF_BYTES
) (
   // control
   input  wire logic                 swap,
   // data
   input  wire logic [BYTES*8-1:0]   din,
   output logic      [BYTES*8-1:0]   dout
);
   // ---------------------------------------------------------------------------
   // per byte lane selection
   // ---------------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < BYTES; g++) begin : g_lane
         // lane g takes its mirror lane when swapping, else itself
         assign dout[g*8 +: 8] = swap ? din[(BYTES-1-g)*8 +: 8] : din[g*8 +: 8];
      end
   endgenerate
endmodule

// ### rtl/cpf_top.sv
// Purpose: framing, clock edge and byte order control of a codec serial port
// Assumes: serial clock comes from the codec and is sampled by CLK_SYS
// Notes:   sample in slot 0 is sent and received most significant bit first
//
// Functional notes
// - long sync spans all of time slot 0
// - short sync lasts one serial clock
// - swap set reverses bytes of each sample
// - swap clear keeps byte order unchanged
// - byte order applies in both directions
// - sync direction set makes sync an input
// - sync direction clear drives generated sync
//
// Local design decisions: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module cpf_top
   import cpf_pkg::*;
(
   // clock and reset
   input  wire logic                    CLK_SYS,
   input  wire logic                    RST_B,
   // avalon-mm slave
   input  wire logic [3:0]              AVS_ADDRESS,
   input  wire logic                    AVS_READ,
   input  wire logic                    AVS_WRITE,
   input  wire logic [31:0]             AVS_WRITEDATA,
   input  wire logic [3:0]              AVS_BYTEENABLE,
   output logic      [31:0]             AVS_READDATA,
   output logic                         AVS_WAITREQUEST,
   // endpoint buffer to port
   input  wire logic [CPF_SAMPLE_W-1:0] EP_TX_DATA,
   input  wire logic                    EP_TX_VALID,
   output logic                         EP_TX_READY,
   // port to endpoint buffer
   output logic      [CPF_SAMPLE_W-1:0] EP_RX_DATA,
   output logic                         EP_RX_VALID,
   // codec pins
   input  wire logic                    PORT_SERIAL_CLOCK,
   input  wire logic                    PORT_FRAME_SYNC_I,
   output logic                         PORT_FRAME_SYNC_O,
   output logic                         PORT_FRAME_SYNC_OE_B,
   output logic                         PORT_SERIAL_OUT,
   input  wire logic                    PORT_SERIAL_IN
);
   // ---------------------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------------------
   logic [1:0] rst_sync_q;   // release shift chain
   logic       rst_n;        // released reset for the rest of the block

   // two stage release of the asynchronous reset
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ---------------------------------------------------------------------------
   // registers and bus slave
   // ---------------------------------------------------------------------------
   cpf_cfg_s    cfg_q;         // configuration bits
   logic [7:0]  slot0_q;       // serial clocks in slot 0
   logic [7:0]  frame_q;       // serial clocks per frame
   logic [7:0]  frm_cnt_q;     // frames started, wraps
   logic        ack_q;         // answer cycle of a bus access
   logic [31:0] rdata_q;       // registered read data
   logic        req;           // access pending
   logic        wr_go;         // write takes effect this edge
   logic [31:0] rd_mux;        // read selection
   logic        tx_full_q;     // transmit holding word full
   logic        fs_q;          // generated sync level
   logic        cfg_wr;        // configuration write this edge
   cpf_cfg_s    cfg_d;         // configuration after this edge

   assign req             = AVS_READ | AVS_WRITE;
   assign AVS_WAITREQUEST = req & ~ack_q;
   assign wr_go           = AVS_WRITE & ack_q & AVS_BYTEENABLE[0];
   assign AVS_READDATA    = rdata_q;
   assign cfg_wr          = wr_go & (AVS_ADDRESS == CPF_ADDR_CFG);
   assign cfg_d           = cfg_wr ? cpf_cfg_s'(AVS_WRITEDATA[CPF_CFG_W-1:0]) : cfg_q;
   assign rd_mux =
      (AVS_ADDRESS == CPF_ADDR_CFG)    ? {26'h0, cfg_q} :
      (AVS_ADDRESS == CPF_ADDR_SLOT0)  ? {24'h0, slot0_q} :
      (AVS_ADDRESS == CPF_ADDR_FRAME)  ? {24'h0, frame_q} :
      (AVS_ADDRESS == CPF_ADDR_STATUS) ? {16'h0, frm_cnt_q, 5'h0, cfg_q.sync_dir,
                                          tx_full_q, PORT_FRAME_SYNC_O} :
      32'h0;

   // one wait cycle per access; read data captured in the wait cycle
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         ack_q   <= req & ~ack_q;
         rdata_q <= (AVS_READ & ~ack_q) ? rd_mux : rdata_q;
      end
   end

   // software writes, low byte lane only, unmapped addresses ignored
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         cfg_q   <= cpf_cfg_s'(CPF_CFG_RST[CPF_CFG_W-1:0]);
         slot0_q <= CPF_SLOT0_RST;
         frame_q <= CPF_FRAME_RST;
      end else if (wr_go) begin
         if (AVS_ADDRESS == CPF_ADDR_CFG) begin
            cfg_q <= cpf_cfg_s'(AVS_WRITEDATA[CPF_CFG_W-1:0]);
         end
         if (AVS_ADDRESS == CPF_ADDR_SLOT0) begin
            slot0_q <= AVS_WRITEDATA[7:0];
         end
         if (AVS_ADDRESS == CPF_ADDR_FRAME) begin
            frame_q <= AVS_WRITEDATA[7:0];
         end
      end
   end

   // ---------------------------------------------------------------------------
   // pin input filtering: clock, sync in, data in
   // ---------------------------------------------------------------------------
   logic [2:0] s1_q, s2_q, s3_q;  // three flip-flop chain per pin
   logic [2:0] lvl_q;             // accepted levels
   logic [2:0] agree;             // second and third stage agree
   logic       sck_rise, sck_fall;
   logic       launch_e, sample_e;

   assign agree    = ~(s2_q ^ s3_q);
   assign sck_rise = agree[0] & s3_q[0] & ~lvl_q[0];
   assign sck_fall = agree[0] & ~s3_q[0] & lvl_q[0];
   assign launch_e = cfg_q.edge_sel ? sck_fall : sck_rise;
   assign sample_e = cfg_q.edge_sel ? sck_rise : sck_fall;

   // synchronise and accept a level once two later stages agree
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         s1_q  <= 3'h0;
         s2_q  <= 3'h0;
         s3_q  <= 3'h0;
         lvl_q <= 3'h0;
      end else begin
         s1_q  <= {PORT_SERIAL_IN, PORT_FRAME_SYNC_I, PORT_SERIAL_CLOCK};
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         lvl_q <= (agree & s3_q) | (~agree & lvl_q);
      end
   end

   // ---------------------------------------------------------------------------
   // frame timing and sync
   // ---------------------------------------------------------------------------
   logic [7:0] bit_cnt_q;   // serial clock index in frame
   logic [7:0] nc;          // index after this launch edge
   logic       start_q;     // external sync seen, frame restarts
   logic       ext_rise;    // external sync rising, accepted
   logic       fs_next;     // generated sync for the next clock

   assign ext_rise = agree[1] & s3_q[1] & ~lvl_q[1];
   assign nc = (cfg_q.sync_dir & start_q) ? 8'h00 :
               (bit_cnt_q >= frame_q - 8'h01) ? 8'h00 : bit_cnt_q + 8'h01;
   assign fs_next = cfg_q.sync_len ? (nc < slot0_q) : (nc == 8'h00);

   assign PORT_FRAME_SYNC_O    = fs_q;
   assign PORT_FRAME_SYNC_OE_B = cfg_q.sync_dir;

   // counter moves on the launch edge; sync too, unless the pin is handed over
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_q <= 8'h00;
         fs_q      <= 1'b0;
         start_q   <= 1'b0;
         frm_cnt_q <= 8'h00;
      end else begin
         start_q <= ext_rise | (start_q & ~launch_e);
         // sync drops in the same edge that hands the pin to the codec
         fs_q    <= ~cfg_d.sync_dir & (launch_e ? fs_next : fs_q);
         if (launch_e) begin
            bit_cnt_q <= nc;
            frm_cnt_q <= (nc == 8'h00) ? frm_cnt_q + 8'h01 : frm_cnt_q;
         end
      end
   end

   // ---------------------------------------------------------------------------
   // sample transfer with byte order selection
   // ---------------------------------------------------------------------------
   logic [CPF_SAMPLE_W-1:0] tx_sw;       // endpoint word after selection
   logic [CPF_SAMPLE_W-1:0] tx_hold_q;   // word waiting for a frame
   logic [CPF_SAMPLE_W-1:0] tx_cur_q;    // word being shifted out
   logic [CPF_SAMPLE_W-1:0] tx_word;     // word feeding the output bit
   logic [CPF_SAMPLE_W-1:0] rx_sh_q;     // received bits
   logic [CPF_SAMPLE_W-1:0] rx_word;     // completed sample
   logic [CPF_SAMPLE_W-1:0] rx_sw;       // completed sample after selection
   logic                    tx_take;     // endpoint word accepted
   logic                    rx_done;     // last sample bit sampled
   logic                    so_q;        // serial output bit
   logic                    rx_v_q;      // receive valid pulse
   logic [CPF_SAMPLE_W-1:0] rx_data_q;   // receive data

   cpf_swap #(.BYTES(CPF_BYTES)) u_tx_swap (
      .swap (cfg_q.byte_swap),
      .din  (EP_TX_DATA),
      .dout (tx_sw)
   );
   cpf_swap #(.BYTES(CPF_BYTES)) u_rx_swap (
      .swap (cfg_q.byte_swap),
      .din  (rx_word),
      .dout (rx_sw)
   );

   assign EP_TX_READY = ~tx_full_q;
   assign tx_take     = EP_TX_VALID & ~tx_full_q;
   assign tx_word     = (nc == 8'h00) ? (tx_full_q ? tx_hold_q : '0) : tx_cur_q;
   assign rx_word     = {rx_sh_q[CPF_SAMPLE_W-2:0], lvl_q[2]};
   assign rx_done     = sample_e & (bit_cnt_q == CPF_SAMPLE_LAST);
   assign PORT_SERIAL_OUT = so_q;
   assign EP_RX_DATA  = rx_data_q;
   assign EP_RX_VALID = rx_v_q;

   // holding word and output shifting on launch edges
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         tx_hold_q <= '0;
         tx_full_q <= 1'b0;
         tx_cur_q  <= '0;
         so_q      <= 1'b0;
      end else begin
         if (tx_take) begin
            tx_hold_q <= tx_sw;
         end
         tx_full_q <= tx_take | (tx_full_q & ~(launch_e & (nc == 8'h00)));
         if (launch_e) begin
            tx_cur_q <= (nc == 8'h00) ? tx_word : tx_cur_q;
            so_q     <= (nc <= CPF_SAMPLE_LAST) ? tx_word[CPF_SAMPLE_LAST[3:0] - nc[3:0]]
                                                : 1'b0;
         end
      end
   end

   // input shifting on sample edges, word out after the last bit
   always_ff @(posedge CLK_SYS or negedge rst_n) begin
      if (!rst_n) begin
         rx_sh_q   <= '0;
         rx_v_q    <= 1'b0;
         rx_data_q <= '0;
      end else begin
         rx_v_q <= rx_done;
         if (sample_e & (bit_cnt_q <= CPF_SAMPLE_LAST)) begin
            rx_sh_q <= rx_word;
         end
         if (rx_done) begin
            rx_data_q <= rx_sw;
         end
      end
   end

   // ---------------------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!rst_n);

   sequence s_drive_launch;
      launch_e & ~cfg_d.sync_dir & ~cfg_q.sync_len;
   endsequence

   sequence s_long_launch;
      launch_e & ~cfg_d.sync_dir & cfg_q.sync_len;
   endsequence

   chk_sync_long: assert property (s_long_launch |=>
      fs_q == (bit_cnt_q < $past(slot0_q)))
      else $error("long sync not spanning slot 0");
   chk_sync_short: assert property (s_drive_launch |=>
      fs_q == (bit_cnt_q == 8'h00))
      else $error("short sync not on first clock only");
   chk_swap_set: assert property (tx_take & cfg_q.byte_swap |=>
      tx_hold_q == {$past(EP_TX_DATA[7:0]), $past(EP_TX_DATA[15:8])})
      else $error("transmit sample not swapped");
   chk_swap_clear: assert property (tx_take & ~cfg_q.byte_swap |=>
      tx_hold_q == $past(EP_TX_DATA))
      else $error("transmit sample altered");
   chk_rx_order: assert property (rx_done |=> rx_v_q && (rx_data_q ==
      ($past(cfg_q.byte_swap) ? {$past(rx_word[7:0]), $past(rx_word[15:8])}
                              : $past(rx_word))))
      else $error("receive byte order wrong");
   chk_sync_input: assert property (cfg_q.sync_dir |-> PORT_FRAME_SYNC_OE_B && !fs_q)
      else $error("sync driven while input");
   chk_sync_output: assert property (launch_e & ~cfg_d.sync_dir & (nc == 8'h00) &
      (slot0_q != 8'h00) |=> PORT_FRAME_SYNC_O && !PORT_FRAME_SYNC_OE_B)
      else $error("sync not driven at frame start");
   chk_launch_edge: assert property ($changed(so_q) |->
      $past(cfg_q.edge_sel ? sck_fall : sck_rise))
      else $error("serial out moved off launch edge");
endmodule

// ### tb/cpf_codec_model.sv
// Purpose: behavioural audio codec at the far side of the serial port
// Assumes: the codec makes the serial clock, a frame holds FRAME clocks
// Notes:   port pins are sampled at launch edges, before the block moves them
`timescale 1ns/1ps
module cpf_codec_model #(
   parameter int FRAME = 32  // serial clocks per frame
) (
   // control from the bench
   input  wire logic        run,
   input  wire logic        edge_sel,
   input  wire logic        sync_dir,
   input  wire logic [15:0] word,
   // port pins
   input  wire logic        sync_pin,
   input  wire logic        ser_out,
   output logic             sclk,
   output logic             sync_drv,
   output logic             ser_in,
   // observations
   output logic      [15:0] rx_word,
   output logic      [7:0]  sync_len,
   output int               nfr,
   output int               nbad
);
   int          idx;  // bit index that just ended
   int          nx;   // bit index now starting
   int          hi;   // clocks seen with sync high
   logic        ps;   // sync level at the previous launch edge
   logic [15:0] sh;   // received bits, msb first
   logic        pd;   // sync direction at the previous launch edge
   logic        so_s; // serial out at the last sample edge
   logic        sy_s; // sync pin at the last sample edge
   // ------------------------------------------------------------------
   // serial clock, phase unrelated to the system clock
   // ------------------------------------------------------------------
   initial begin
      {sclk, sync_drv, ser_in, ps, sh, rx_word, sync_len, pd, so_s, sy_s} = '0;
      nbad = 0;
      idx = 0;
      nx = 0;
      hi = 0;
      nfr = 0;
      #7;
      forever #80 if (run) sclk = ~sclk;
   end
   // ------------------------------------------------------------------
   // launch edge: take the ended bit, then launch the next one
   // ------------------------------------------------------------------
   always @(sclk) begin
      if (run && sclk == !edge_sel) begin
         // data and sync must not move between sample and launch edge
         if (so_s !== ser_out || sy_s !== sync_pin) nbad++;
         // own sync leads the frame by one clock in input mode
         if (sync_pin && !ps) idx = sync_dir ? FRAME - 1 : 0;
         else idx = (idx + 1) % FRAME;
         // entering input mode the codec starts its frames out of step
         if (sync_dir && !pd) idx = (idx + 7) % FRAME;
         pd = sync_dir;
         ps = sync_pin;
         if (idx < 16) sh = {sh[14:0], ser_out};
         if (idx == 15) begin
            rx_word = sh;
            nfr++;
         end
         // length of the last sync pulse in serial clocks
         if (sync_pin) hi++;
         else if (hi != 0) begin
            sync_len = hi[7:0];
            hi = 0;
         end
         nx = (idx + 1) % FRAME;
         ser_in = (nx < 16) ? word[15 - nx] : ~ser_in;  // idle slots toggle
         sync_drv = sync_dir && (nx == FRAME - 1);
      end
   end
   // sample edge: note the pins that the next launch edge compares
   always @(sclk) begin
      if (run && sclk == edge_sel) begin
         so_s = ser_out;
         sy_s = sync_pin;
      end
   end
endmodule

// ### tb/codec_port_frame_config_tb.sv
// Purpose: self-checking bench of the codec port frame configuration block
// Assumes: registers at their reset layout, frame of 32 clocks
// Notes:   table rows cover framing, edges and byte order; hand tests after
`timescale 1ns/1ps
module codec_port_frame_config_tb;
   import cpf_pkg::*;
   typedef struct packed {
      logic [7:0]  cfg;  // config written
      logic [15:0] tx;   // endpoint word sent
      logic [15:0] cw;   // codec word sent
      logic [7:0]  len;  // sync length expected
      logic [15:0] out;  // serial word expected
      logic [15:0] rx;   // endpoint word expected
   } cpf_row_s;
   logic        clk_sys = 0, rst_b = 0, run = 0, tx_valid = 0;
   logic [3:0]  avs_address = 0, avs_byteenable = 0;
   logic        avs_read = 0, avs_write = 0;
   logic [31:0] avs_writedata = 0, rdata;
   logic [15:0] tx_data = 0, cw = 0, last_rx = 0;
   logic [7:0]  cfg_v = 8'h30;
   wire  [31:0] avs_readdata;
   wire  [15:0] rx_data, c_rx_word;
   wire  [7:0]  c_sync_len;
   wire         waitreq, tx_ready, rx_valid, sclk, c_sync, ser_in, sync_o, oe_b, ser_out;
   wire         sync_w = oe_b ? c_sync : sync_o;  // resolved sync wire
   int          c_nfr, c_bad, err_total = 0, samples_checked = 0, cyc = 0;
   cpf_row_s    rows [5] = '{
      '{8'h30, 16'h12C4, 16'h9E31, 8'h01, 16'h12C4, 16'h9E31},
      '{8'h38, 16'hB70D, 16'h4A63, 8'h10, 16'hB70D, 16'h4A63},
      '{8'h34, 16'h12C4, 16'h9E31, 8'h01, 16'hC412, 16'h319E},
      '{8'h10, 16'h8001, 16'h7FFE, 8'h01, 16'h8001, 16'h7FFE},
      '{8'h1C, 16'h3CA5, 16'hC35A, 8'h10, 16'hA53C, 16'h5AC3}};
   // ------------------------------------------------------------------
   // clock, design, codec
   // ------------------------------------------------------------------
   always #10 clk_sys = ~clk_sys;
   cpf_top cpf_top_i (.CLK_SYS(clk_sys), .RST_B(rst_b), .AVS_ADDRESS(avs_address),
      .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
      .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
      .AVS_WAITREQUEST(waitreq), .EP_TX_DATA(tx_data), .EP_TX_VALID(tx_valid),
      .EP_TX_READY(tx_ready), .EP_RX_DATA(rx_data), .EP_RX_VALID(rx_valid),
      .PORT_SERIAL_CLOCK(sclk), .PORT_FRAME_SYNC_I(sync_w), .PORT_FRAME_SYNC_O(sync_o),
      .PORT_FRAME_SYNC_OE_B(oe_b), .PORT_SERIAL_OUT(ser_out), .PORT_SERIAL_IN(ser_in));
   cpf_codec_model cpf_codec_model_i (.run(run), .edge_sel(cfg_v[5]), .sync_dir(cfg_v[0]),
      .word(cw), .sync_pin(sync_w), .ser_out(ser_out), .sclk(sclk), .sync_drv(c_sync),
      .ser_in(ser_in), .rx_word(c_rx_word), .sync_len(c_sync_len), .nfr(c_nfr),
      .nbad(c_bad));
   // keep the last received endpoint word
   always @(posedge clk_sys) if (rx_valid === 1'b1) last_rx <= rx_data;
   // hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         end_sim();
      end
   end
   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] be);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clk_sys); while (waitreq !== 1'b0);
      rdata = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic frames(input int n);
      int s;
      s = c_nfr;
      while (c_nfr < s + n) @(posedge clk_sys);
   endtask
   task automatic run_row(input cpf_row_s r);
      int b0;
      bus(1'b1, CPF_ADDR_CFG, r.cfg, 4'hF);
      cfg_v <= r.cfg;
      cw <= r.cw;
      frames(3);
      b0 = c_bad;
      @(posedge clk_sys);
      tx_data <= r.tx;
      tx_valid <= 1'b1;
      do @(posedge clk_sys); while (tx_ready !== 1'b1);
      tx_valid <= 1'b0;
      do @(posedge clk_sys); while (tx_ready !== 1'b1);
      frames(1);
      // let the endpoint word land before it is compared
      repeat (2) @(posedge clk_sys);
      chk(c_sync_len, r.len, "sync length");
      chk(c_rx_word, r.out, "serial word");
      chk(last_rx, r.rx, "endpoint word");
      chk(c_bad - b0, 32'h0, "pins moved off launch edge");
      $display("test cfg %h done", r.cfg);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk(oe_b, 1'b0, "sync enable after reset");
      bus(1'b0, CPF_ADDR_CFG, 8'h00, 4'h0);
      chk(rdata, 32'h30, "cfg reset");
      bus(1'b0, CPF_ADDR_SLOT0, 8'h00, 4'h0);
      chk(rdata, 32'h10, "slot reset");
      bus(1'b0, CPF_ADDR_FRAME, 8'h00, 4'h0);
      chk(rdata, 32'h20, "frame reset");
      bus(1'b0, 4'h2, 8'h00, 4'h0);
      chk(rdata, 32'h0, "unmapped read");
      bus(1'b1, CPF_ADDR_CFG, 8'h3C, 4'h0);
      bus(1'b0, CPF_ADDR_CFG, 8'h00, 4'h0);
      chk(rdata, 32'h30, "write without lane");
      $display("test registers done");
      run <= 1'b1;
      foreach (rows[i]) run_row(rows[i]);
      // shorter long sync: slot 0 of eight clocks
      bus(1'b1, CPF_ADDR_SLOT0, 8'h08, 4'hF);
      run_row('{8'h38, 16'h6E13, 16'h2D95, 8'h08, 16'h6E13, 16'h2D95});
      bus(1'b1, CPF_ADDR_SLOT0, 8'h10, 4'hF);
      // sync from the codec, bytes swapped
      run_row('{8'h35, 16'h5E21, 16'h0B7C, 8'h01, 16'h215E, 16'h7C0B});
      chk(oe_b, 1'b1, "sync enable input mode");
      chk(sync_o, 1'b0, "sync out input mode");
      bus(1'b0, CPF_ADDR_STATUS, 8'h00, 4'h0);
      chk(rdata[CPF_ST_DIR], 1'b1, "status direction");
      bus(1'b1, CPF_ADDR_CFG, 8'h30, 4'hF);
      @(posedge clk_sys);
      chk(oe_b, 1'b0, "sync enable output mode");
      $display("test sync direction done");
      // reset in mid-run brings the registers back
      bus(1'b1, CPF_ADDR_SLOT0, 8'h2A, 4'hF);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk(tx_ready, 1'b1, "ready after reset");
      bus(1'b0, CPF_ADDR_SLOT0, 8'h00, 4'h0);
      chk(rdata, 32'h10, "slot after reset");
      $display("test reset done");
      end_sim();
   end
endmodule
